// ==== core/lcd_blink_pkg.sv ====
// package: register map, field positions, reset values and sizes
// assumes a plain synchronous register port, byte-wide registers
package lcd_blink_pkg;
  localparam int unsigned NUM_FP     = 8;
  localparam int unsigned NUM_BP     = 4;
  localparam int unsigned ADDR_W     = 4;
  localparam int unsigned RATE_W     = 3;
  localparam int unsigned DIV_W      = 12;

  // register indices (byte addresses on the plain port)
  localparam logic [3:0] ADDR_BLINK_CTL  = 4'h0;
  localparam logic [3:0] ADDR_CMD_STATUS = 4'h1;
  localparam logic [3:0] ADDR_MAIN_CTL   = 4'h2;
  localparam logic [3:0] ADDR_FP_ENABLE  = 4'h3;
  localparam logic [3:0] ADDR_IRQ_STATUS = 4'h4;
  localparam logic [3:0] ADDR_IRQ_MASK   = 4'h5;
  localparam logic [3:0] ADDR_SEG_BASE   = 4'h8;

  // blink_control fields
  localparam int unsigned BC_BLINK_BIT = 7;
  localparam int unsigned BC_MODE_BIT  = 3;
  // display_command_status fields
  localparam int unsigned CMD_IF_BIT    = 7;
  localparam int unsigned CMD_GROUP_BIT = 3;
  localparam int unsigned CMD_CLEAR_BIT = 1;
  localparam int unsigned CMD_BLANK_BIT = 0;
  // main_control_register fields
  localparam int unsigned MC_EN_BIT     = 7;
  localparam int unsigned MC_FIE_BIT    = 6;
  localparam int unsigned MC_DUTY_LO    = 0;

  // irq status bit positions
  localparam int unsigned IRQ_FRAME_BIT = 0;
  localparam int unsigned IRQ_CLEAR_BIT = 1;

  localparam logic [7:0] BLINK_CTL_RESET = 8'h00;
  localparam logic [7:0] MAIN_CTL_RESET  = 8'h01;
  localparam logic [7:0] ZERO_BYTE       = 8'h00;

  // waveform base clock ticks per backplane phase
  localparam logic [DIV_W-1:0] PHASE_TICKS = 12'h0040;
  localparam int unsigned      BLINK_BASE  = 5;

  typedef enum logic [1:0] {
    DUTY_RSVD = 2'b00,
    DUTY_HALF = 2'b01,
    DUTY_THIRD = 2'b10,
    DUTY_QUARTER = 2'b11
  } duty_t;
endpackage : lcd_blink_pkg

// ==== core/blink_divider.sv ====
// blink divider: counts frames of base clock ticks, toggles blink phase
// assumes tick is a one-cycle pulse per completed frame
module blink_divider (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       frame_tick,
  input  wire logic       run,
  input  wire logic [2:0] rate,
  input  wire logic [15:0] frame_ticks_per_frame,
  output logic            phase_q
);
  logic [15:0] frames_q;
  logic [15:0] half_period;

  // blink half period (time between phase toggles) in base ticks is 2^(5+rate); counted as whole frames
  always_comb begin
    half_period = 16'(32'd1 << (lcd_blink_pkg::BLINK_BASE + 32'(rate))) / frame_ticks_per_frame;
    if (half_period == 16'h0000) begin
      half_period = 16'h0001;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      frames_q <= 16'h0000;
      phase_q  <= 1'b0;
    end else if (!run) begin
      frames_q <= 16'h0000;
      phase_q  <= 1'b0;
    end else if (frame_tick) begin // R18
      if (frames_q + 16'h0001 >= half_period) begin
        frames_q <= 16'h0000;
        phase_q  <= ~phase_q;
      end else begin
        frames_q <= frames_q + 16'h0001;
      end
    end
  end
endmodule : blink_divider

// ==== core/lcd_blink_cmd.sv ====
// segment LCD blink and command/status block with segment memory
// assumes clk is the waveform base clock; registers on a plain byte port
// Behaviour
// [R1] blink start or stop is applied only at the next frame start; the code applies it every cycle while module enable is clear
// [R2] blink rate is base clock divided by two to the five plus rate
// [R3] mode one blinks every segment; mode zero only blink-enabled segments
// [R4] with blinking stopped the mode bit has no effect
// [R5] software should not change rate or mode while blinking
// [R6] flag bit 7 set by hardware, cleared by read then write one
// [R7] group select bit 3 picks on/off bits or blink-enable bits
// [R8] clear command zeroes the selected group then drops by itself
// [R9] clear command bit always reads as zero
// [R10] blank forces all segments off, memory untouched
// [R11] blanking keeps frame timing running
// [R12] unblanked segments follow their on/off bit
// [R13] pin drives only with its pin enable and module enable set
// [R14] with on/off group selected, writing one turns a segment on
// [R15] software configures everything before setting module enable
// [R16] duty field picks two, three or four backplanes; 00 reserved
// [R17] interrupt request while flag and frame interrupt enable set
// [R18] blinking segments alternate shown and off over whole frames
//
// The register addresses and the plain strobed port were left to the implementer.
module lcd_blink_cmd (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic [3:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata_q,
  output logic      [7:0] fp_out_q,
  output logic      [7:0] fp_oe_q,
  output logic      [3:0] bp_active_q,
  output logic            irq_q,
  output logic            frame_irq_q
);
  localparam int unsigned NFP = lcd_blink_pkg::NUM_FP;
  localparam int unsigned NBP = lcd_blink_pkg::NUM_BP;

  logic [7:0]     blink_ctl_q;
  logic           group_sel_q;
  logic           blank_q;
  logic           flag_q;
  logic           flag_armed_q;
  logic           clear_busy_q;
  logic [7:0]     main_ctl_q;
  logic [7:0]     fp_en_q;
  logic [1:0]     irq_stat_q;
  logic [1:0]     irq_mask_q;
  logic [NBP-1:0] seg_on_q    [NFP];
  logic [NBP-1:0] seg_blink_q [NFP];
  logic           blink_run_q;
  logic [11:0]    tick_q;
  logic [1:0]     bp_idx_q;
  logic           frame_tick;
  logic           blink_phase;
  logic [1:0]     bp_count;
  logic           module_en;
  logic [3:0]     seg_idx;
  logic           seg_sel;
  logic           cmd_rd;
  logic           flag_wr_clr;
  logic [15:0]    frame_len;

  // decode a segment memory address, used by reads and writes
  function automatic logic seg_hit(input logic [3:0] a);
    seg_hit = (a >= lcd_blink_pkg::ADDR_SEG_BASE);
  endfunction : seg_hit

  function automatic logic [1:0] bp_last(input logic [1:0] duty);
    unique case (duty)
      lcd_blink_pkg::DUTY_HALF:  bp_last = 2'd1;
      lcd_blink_pkg::DUTY_THIRD: bp_last = 2'd2;
      default:                   bp_last = 2'd3; // reserved falls back to four
    endcase
  endfunction : bp_last

  assign module_en   = main_ctl_q[lcd_blink_pkg::MC_EN_BIT];
  assign bp_count    = bp_last(main_ctl_q[lcd_blink_pkg::MC_DUTY_LO +: 2]); // R16
  assign seg_idx     = addr - lcd_blink_pkg::ADDR_SEG_BASE;
  assign seg_sel     = seg_hit(addr);
  assign cmd_rd      = rd && addr == lcd_blink_pkg::ADDR_CMD_STATUS;
  assign flag_wr_clr = wr && addr == lcd_blink_pkg::ADDR_CMD_STATUS
                       && wdata[lcd_blink_pkg::CMD_IF_BIT] && flag_armed_q;
  assign frame_tick  = tick_q == lcd_blink_pkg::PHASE_TICKS - 12'h001 && bp_idx_q == bp_count;
  // widen before adding one: the 2-bit count would wrap to zero at quarter duty
  assign frame_len   = {4'h0, lcd_blink_pkg::PHASE_TICKS} * ({14'h0000, bp_count} + 16'h0001);

  // frame timer runs whenever enabled, blank does not stop it
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tick_q   <= 12'h000;
      bp_idx_q <= 2'd0;
    end else if (!module_en) begin
      tick_q   <= 12'h000;
      bp_idx_q <= 2'd0;
    end else if (tick_q == lcd_blink_pkg::PHASE_TICKS - 12'h001) begin // R11
      tick_q   <= 12'h000;
      bp_idx_q <= (bp_idx_q == bp_count) ? 2'd0 : bp_idx_q + 2'd1;
    end else begin
      tick_q <= tick_q + 12'h001;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      blink_ctl_q <= lcd_blink_pkg::BLINK_CTL_RESET;
      main_ctl_q  <= lcd_blink_pkg::MAIN_CTL_RESET;
      fp_en_q     <= lcd_blink_pkg::ZERO_BYTE;
      irq_mask_q  <= 2'b00;
      group_sel_q <= 1'b0;
      blank_q     <= 1'b0;
    end else if (wr) begin
      unique case (addr)
        lcd_blink_pkg::ADDR_BLINK_CTL: blink_ctl_q <= wdata & 8'h8F;
        lcd_blink_pkg::ADDR_MAIN_CTL:  main_ctl_q  <= wdata;
        lcd_blink_pkg::ADDR_FP_ENABLE: fp_en_q     <= wdata;
        lcd_blink_pkg::ADDR_IRQ_MASK:  irq_mask_q  <= wdata[1:0];
        lcd_blink_pkg::ADDR_CMD_STATUS: begin
          group_sel_q <= wdata[lcd_blink_pkg::CMD_GROUP_BIT]; // R7
          blank_q     <= wdata[lcd_blink_pkg::CMD_BLANK_BIT];
        end
        default: ;
      endcase
    end
  end

  // blink start/stop latched at frame boundary, or every cycle while module disabled
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      blink_run_q <= 1'b0;
    end else if (frame_tick || !module_en) begin // R1
      blink_run_q <= blink_ctl_q[lcd_blink_pkg::BC_BLINK_BIT];
    end
  end

  blink_divider u_blink (
    .clk                   (clk),
    .reset_n               (reset_n),
    .frame_tick            (frame_tick),
    .run                   (blink_run_q),
    .rate                  (blink_ctl_q[2:0]), // R2
    .frame_ticks_per_frame (frame_len),
    .phase_q               (blink_phase)
  );

  // segment memory: two groups, clear command sweeps the selected one
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < NFP; i++) begin
        seg_on_q[i]    <= '0;
        seg_blink_q[i] <= '0;
      end
      clear_busy_q <= 1'b0;
    end else if (clear_busy_q) begin // R8
      for (int i = 0; i < NFP; i++) begin
        if (group_sel_q) seg_blink_q[i] <= '0;
        else             seg_on_q[i]    <= '0;
      end
      clear_busy_q <= 1'b0;
    end else if (wr && addr == lcd_blink_pkg::ADDR_CMD_STATUS
                 && wdata[lcd_blink_pkg::CMD_CLEAR_BIT]) begin
      clear_busy_q <= 1'b1;
    end else if (wr && seg_sel && seg_idx < 4'(NFP)) begin
      if (group_sel_q) seg_blink_q[seg_idx[2:0]] <= wdata[NBP-1:0]; // R7
      else             seg_on_q[seg_idx[2:0]]    <= wdata[NBP-1:0]; // R14
    end
  end

  // frame flag: set wins over clear; clear needs a prior read of the register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      flag_q       <= 1'b0;
      flag_armed_q <= 1'b0;
    end else begin
      if (frame_tick) begin // R6
        flag_q <= 1'b1;
      end else if (flag_wr_clr) begin
        flag_q <= 1'b0;
      end
      if (cmd_rd && flag_q) flag_armed_q <= 1'b1;
      else if (flag_wr_clr || !flag_q) flag_armed_q <= 1'b0;
    end
  end

  // sticky status, cleared by reading it; set wins
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_stat_q <= 2'b00;
    end else begin
      for (int b = 0; b < 2; b++) begin
        if ((b == lcd_blink_pkg::IRQ_FRAME_BIT && frame_tick)
            || (b == lcd_blink_pkg::IRQ_CLEAR_BIT && clear_busy_q)) begin
          irq_stat_q[b] <= 1'b1;
        end else if (rd && addr == lcd_blink_pkg::ADDR_IRQ_STATUS) begin
          irq_stat_q[b] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_q       <= 1'b0;
      frame_irq_q <= 1'b0;
    end else begin
      irq_q       <= |(irq_stat_q & irq_mask_q);
      frame_irq_q <= flag_q && main_ctl_q[lcd_blink_pkg::MC_FIE_BIT]; // R17
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_q <= lcd_blink_pkg::ZERO_BYTE;
    end else if (rd) begin
      unique case (addr)
        lcd_blink_pkg::ADDR_BLINK_CTL:  rdata_q <= blink_ctl_q;
        lcd_blink_pkg::ADDR_CMD_STATUS: rdata_q <= {flag_q, 3'b000, group_sel_q,
                                                    1'b0, 1'b0, blank_q}; // R9
        lcd_blink_pkg::ADDR_MAIN_CTL:   rdata_q <= main_ctl_q;
        lcd_blink_pkg::ADDR_FP_ENABLE:  rdata_q <= fp_en_q;
        lcd_blink_pkg::ADDR_IRQ_STATUS: rdata_q <= {6'h00, irq_stat_q};
        lcd_blink_pkg::ADDR_IRQ_MASK:   rdata_q <= {6'h00, irq_mask_q};
        default: begin
          if (seg_sel && seg_idx < 4'(NFP)) begin
            rdata_q <= {4'h0, group_sel_q ? seg_blink_q[seg_idx[2:0]]
                                          : seg_on_q[seg_idx[2:0]]};
          end else begin
            rdata_q <= lcd_blink_pkg::ZERO_BYTE;
          end
        end
      endcase
    end else begin
      rdata_q <= lcd_blink_pkg::ZERO_BYTE;
    end
  end

  // per-pin segment level for the active backplane
  generate
    for (genvar p = 0; p < NFP; p++) begin : g_fp
      logic blinks;
      logic shown;
      assign blinks = blink_run_q && (blink_ctl_q[lcd_blink_pkg::BC_MODE_BIT]
                      || seg_blink_q[p][bp_idx_q]); // R3 R4
      assign shown  = !blank_q && seg_on_q[p][bp_idx_q] // R10 R12
                      && !(blinks && blink_phase); // R18
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          fp_out_q[p] <= 1'b0;
          fp_oe_q[p]  <= 1'b0;
        end else begin
          fp_oe_q[p]  <= fp_en_q[p] && module_en; // R13
          fp_out_q[p] <= shown && fp_en_q[p] && module_en;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bp_active_q <= 4'h0;
    end else begin
      bp_active_q <= module_en ? 4'(4'h1 << bp_idx_q) : 4'h0; // R16
    end
  end

  frame_flag_a: assert property (@(posedge clk) disable iff (!reset_n) // R6
    frame_tick |=> flag_q) else $error("frame flag not set");
  clear_read_zero_a: assert property (@(posedge clk) disable iff (!reset_n) // R9
    $past(cmd_rd) |-> !rdata_q[lcd_blink_pkg::CMD_CLEAR_BIT])
    else $error("clear bit read nonzero");
  blank_off_a: assert property (@(posedge clk) disable iff (!reset_n) // R10
    blank_q |=> fp_out_q == 8'h00) else $error("blank leaks segment");
  pin_enable_a: assert property (@(posedge clk) disable iff (!reset_n) // R13
    !module_en |=> fp_oe_q == 8'h00) else $error("pin driven while off");
  blink_sync_a: assert property (@(posedge clk) disable iff (!reset_n) // R1
    module_en && $changed(blink_run_q) |-> $past(frame_tick) || !$past(module_en))
    else $error("blink changed mid frame");
  clear_done_a: assert property (@(posedge clk) disable iff (!reset_n) // R8
    clear_busy_q && !group_sel_q |=> seg_on_q[0] == '0)
    else $error("clear did not zero");
  frame_irq_a: assert property (@(posedge clk) disable iff (!reset_n) // R17
    flag_q && main_ctl_q[lcd_blink_pkg::MC_FIE_BIT] |=> frame_irq_q)
    else $error("frame irq missing");
  timer_blank_a: assert property (@(posedge clk) disable iff (!reset_n) // R11
    module_en && blank_q && tick_q == 12'h000 ##1 module_en |-> tick_q == 12'h001)
    else $error("timer stopped by blank");

  // guards on flag clearing, backplane select, blink stop, read port and irq level
  flag_hold_a: assert property (@(posedge clk) disable iff (!reset_n) // R6
    flag_q && !flag_armed_q |=> flag_q)
    else $error("flag cleared without read");
  bp_onehot_a: assert property (@(posedge clk) disable iff (!reset_n) // R16
    module_en |=> $onehot(bp_active_q))
    else $error("backplane select not one hot");
  blink_stop_a: assert property (@(posedge clk) disable iff (!reset_n) // R4
    !blink_run_q |=> !blink_phase)
    else $error("blink phase while stopped");
  rdata_idle_a: assert property (@(posedge clk) disable iff (!reset_n)
    !rd |=> rdata_q == 8'h00)
    else $error("read data without read");
  irq_level_a: assert property (@(posedge clk) disable iff (!reset_n)
    |(irq_stat_q & irq_mask_q) |=> irq_q)
    else $error("irq level missing");
endmodule : lcd_blink_cmd

// ==== test/lcd_glass_model.sv ====
// glass model: records which backplanes of pin 0 showed lit or dark
// assumes segment levels matter only while the pin output enable is high
module lcd_glass_model (
  input  wire logic       clk,
  input  wire logic       clr,
  input  wire logic [7:0] fp_out,
  input  wire logic [7:0] fp_oe,
  input  wire logic [3:0] bp_active,
  output logic      [3:0] on_seen,
  output logic      [3:0] off_seen,
  output logic      [3:0] bp_seen,
  output logic            any_lit
);
  timeunit 1ns;
  timeprecision 1ns;
  always @(posedge clk) begin
    if (clr) begin
      on_seen  <= 4'h0;
      off_seen <= 4'h0;
      bp_seen  <= 4'h0;
      any_lit  <= 1'b0;
    end else begin
      bp_seen <= bp_seen | bp_active;
      // an undriven pin records its segments as neither lit nor dark
      if (fp_oe[0]) begin
        on_seen  <= on_seen | (bp_active & {4{fp_out[0]}});
        off_seen <= off_seen | (bp_active & {4{~fp_out[0]}});
      end
      any_lit <= any_lit | ((|(fp_out & fp_oe)) & (|bp_active));
    end
  end
endmodule : lcd_glass_model

// ==== test/tb_lcd_blink_cmd.sv ====
// testbench: register port driver, glass model, self-checking scenarios
// assumes duty 1/2 frame of 128 clocks, quarter duty frame of 256
module tb_lcd_blink_cmd;
  timeunit 1ns;
  timeprecision 1ns;
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin errors++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (a), (b)); end end
  localparam int FR = 128;
  logic       clk = 1'b0;
  logic       reset_n = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic       clr = 1'b0;
  logic [7:0] rdata_q, fp_out_q, fp_oe_q, d;
  logic [3:0] bp_active_q, on_seen, off_seen, bp_seen;
  logic       irq_q, frame_irq_q, any_lit;
  int         errors = 0;
  int         comparisons = 0;
  always #10 clk = ~clk;
  lcd_blink_cmd DUT (.clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata_q(rdata_q), .fp_out_q(fp_out_q), .fp_oe_q(fp_oe_q),
    .bp_active_q(bp_active_q), .irq_q(irq_q), .frame_irq_q(frame_irq_q));
  lcd_glass_model glass (.clk(clk), .clr(clr), .fp_out(fp_out_q), .fp_oe(fp_oe_q),
    .bp_active(bp_active_q), .on_seen(on_seen), .off_seen(off_seen),
    .bp_seen(bp_seen), .any_lit(any_lit));
  task automatic end_of_test();
    if (errors == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_of_test
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a; wdata <= v; wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a; rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata_q;
  endtask : rd_reg
  task automatic watch(input int n);
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (n) @(posedge clk);
    #1;
  endtask : watch
  // bounded search for the first backplane of a new frame
  task automatic wait_frame();
    int i;
    for (i = 0; i < 300 && bp_active_q === 4'h1; i++) @(posedge clk);
    for (i = 0; i < 300 && bp_active_q !== 4'h1; i++) @(posedge clk);
    if (i == 300) begin errors++; end_of_test(); end
  endtask : wait_frame
  task automatic t_reset();
    rd_reg(lcd_blink_pkg::ADDR_BLINK_CTL, d);  `CHK(d, 8'h00)
    rd_reg(lcd_blink_pkg::ADDR_MAIN_CTL, d);   `CHK(d, 8'h01)
    rd_reg(lcd_blink_pkg::ADDR_CMD_STATUS, d); `CHK(d, 8'h00)
    rd_reg(4'h6, d);                           `CHK(d, 8'h00)
    `CHK(fp_oe_q, 8'h00)
  endtask : t_reset
  task automatic t_show();
    // configure pins and segments before module enable
    wr_reg(lcd_blink_pkg::ADDR_FP_ENABLE, 8'hff);
    wr_reg(lcd_blink_pkg::ADDR_SEG_BASE, 8'h01);
    wr_reg(lcd_blink_pkg::ADDR_MAIN_CTL, 8'hc1);
    watch(2 * FR);
    `CHK(fp_oe_q, 8'hff)
    `CHK(on_seen, 4'h1)
    `CHK(off_seen, 4'h2)
    wr_reg(lcd_blink_pkg::ADDR_SEG_BASE, 8'h03);
    watch(2 * FR);
    `CHK(on_seen, 4'h3)
  endtask : t_show
  task automatic t_group();
    wr_reg(lcd_blink_pkg::ADDR_CMD_STATUS, 8'h08);
    wr_reg(lcd_blink_pkg::ADDR_SEG_BASE, 8'h01);
    rd_reg(lcd_blink_pkg::ADDR_SEG_BASE, d); `CHK(d, 8'h01)
    wr_reg(lcd_blink_pkg::ADDR_CMD_STATUS, 8'h00);
    rd_reg(lcd_blink_pkg::ADDR_SEG_BASE, d); `CHK(d, 8'h03)
  endtask : t_group
  task automatic t_blink();
    wr_reg(lcd_blink_pkg::ADDR_BLINK_CTL, 8'h80);
    repeat (FR) @(posedge clk);
    watch(6 * FR);
    `CHK(on_seen, 4'h3)
    `CHK(off_seen, 4'h1)
    // mode changes only while stopped
    wr_reg(lcd_blink_pkg::ADDR_BLINK_CTL, 8'h00);
    repeat (2 * FR) @(posedge clk);
    wr_reg(lcd_blink_pkg::ADDR_BLINK_CTL, 8'h08);
    watch(6 * FR);
    `CHK(off_seen, 4'h0)
    wr_reg(lcd_blink_pkg::ADDR_BLINK_CTL, 8'h88);
    repeat (FR) @(posedge clk);
    watch(6 * FR);
    `CHK(off_seen, 4'h3)
    wr_reg(lcd_blink_pkg::ADDR_BLINK_CTL, 8'h08);
    repeat (2 * FR) @(posedge clk);
  endtask : t_blink
  task automatic t_blank();
    wr_reg(lcd_blink_pkg::ADDR_CMD_STATUS, 8'h01);
    watch(2 * FR);
    `CHK(any_lit, 1'b0)
    `CHK(bp_seen, 4'h3)
    wr_reg(lcd_blink_pkg::ADDR_CMD_STATUS, 8'h00);
    rd_reg(lcd_blink_pkg::ADDR_SEG_BASE, d); `CHK(d, 8'h03)
  endtask : t_blank
  task automatic t_clear();
    wr_reg(lcd_blink_pkg::ADDR_IRQ_MASK, 8'h02);
    wr_reg(lcd_blink_pkg::ADDR_CMD_STATUS, 8'h0a);
    rd_reg(lcd_blink_pkg::ADDR_CMD_STATUS, d); `CHK(d[1], 1'b0)
    rd_reg(lcd_blink_pkg::ADDR_SEG_BASE, d);   `CHK(d, 8'h00)
    `CHK(irq_q, 1'b1)
    wr_reg(lcd_blink_pkg::ADDR_IRQ_MASK, 8'h00);
    repeat (2) @(posedge clk);
    #1 `CHK(irq_q, 1'b0)
    wr_reg(lcd_blink_pkg::ADDR_IRQ_MASK, 8'h02);
    rd_reg(lcd_blink_pkg::ADDR_IRQ_STATUS, d); `CHK(d[1], 1'b1)
    repeat (2) @(posedge clk);
    #1 `CHK(irq_q, 1'b0)
    wr_reg(lcd_blink_pkg::ADDR_CMD_STATUS, 8'h00);
    rd_reg(lcd_blink_pkg::ADDR_SEG_BASE, d);   `CHK(d, 8'h03)
    wr_reg(lcd_blink_pkg::ADDR_CMD_STATUS, 8'h02);
    rd_reg(lcd_blink_pkg::ADDR_SEG_BASE, d);   `CHK(d, 8'h00)
  endtask : t_clear
  task automatic t_flag();
    wait_frame();
    rd_reg(lcd_blink_pkg::ADDR_CMD_STATUS, d); `CHK(d[7], 1'b1)
    `CHK(frame_irq_q, 1'b1)
    wr_reg(lcd_blink_pkg::ADDR_CMD_STATUS, 8'h80);
    rd_reg(lcd_blink_pkg::ADDR_CMD_STATUS, d); `CHK(d[7], 1'b0)
    `CHK(frame_irq_q, 1'b0)
    wait_frame();
    // write-one without a prior read must leave the flag set
    wr_reg(lcd_blink_pkg::ADDR_CMD_STATUS, 8'h80);
    rd_reg(lcd_blink_pkg::ADDR_CMD_STATUS, d); `CHK(d[7], 1'b1)
    repeat (3) @(posedge clk);
    #1 `CHK(frame_irq_q, 1'b1)
    wr_reg(lcd_blink_pkg::ADDR_MAIN_CTL, 8'h81);
    repeat (2) @(posedge clk);
    #1 `CHK(frame_irq_q, 1'b0)
  endtask : t_flag
  task automatic t_duty();
    logic [3:0] exp [4];
    int k;
    exp = '{4'hf, 4'h3, 4'h7, 4'hf};
    for (k = 0; k < 4; k++) begin
      wr_reg(lcd_blink_pkg::ADDR_MAIN_CTL, 8'h40 | 8'(k));
      repeat (2) @(posedge clk);
      #1 `CHK(bp_active_q, 4'h0)
      wr_reg(lcd_blink_pkg::ADDR_MAIN_CTL, 8'hc0 | 8'(k));
      watch(2 * 2 * FR);
      `CHK(bp_seen, exp[k])
    end
  endtask : t_duty
  initial begin
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    t_reset();
    t_show();
    t_group();
    t_blink();
    t_blank();
    t_clear();
    t_flag();
    t_duty();
    end_of_test();
  end
  initial begin
    #2_000_000;
    errors++;
    end_of_test();
  end
endmodule : tb_lcd_blink_cmd
